//--- rtl/tsev_pkg.sv
// package for the two-wire master subscription and event flag bank
// assumes one 40 MHz clock domain shared with the transaction engine
package tsev_pkg;

  localparam int unsigned NUM_CHANNELS = 16;
  localparam int unsigned CHAN_IDX_W   = 4;
  localparam int unsigned NUM_TASKS    = 5;
  localparam int unsigned NUM_EVENTS   = 5;
  localparam int unsigned ADDR_W       = 12;

  // subscription register offsets
  localparam logic [11:0] OFS_SUB_RX      = 12'h080;
  localparam logic [11:0] OFS_SUB_TX      = 12'h088;
  localparam logic [11:0] OFS_SUB_STOP    = 12'h094;
  localparam logic [11:0] OFS_SUB_SUSPEND = 12'h09c;
  localparam logic [11:0] OFS_SUB_RESUME  = 12'h0a0;

  // event flag offsets
  localparam logic [11:0] OFS_EV_STOPPED   = 12'h104;
  localparam logic [11:0] OFS_EV_ERROR     = 12'h124;
  localparam logic [11:0] OFS_EV_SUSPENDED = 12'h148;
  localparam logic [11:0] OFS_EV_RX_BEGAN  = 12'h14c;
  localparam logic [11:0] OFS_EV_TX_BEGAN  = 12'h150;

  // subscription field layout
  localparam int unsigned SUB_CHANNEL_INDEX_LSB = 0;
  localparam int unsigned SUB_EN_BIT    = 31;
  localparam logic [31:0] SUB_RESET     = 32'h0000_0000;
  localparam logic        EV_RESET      = 1'b0;

  // task and event index order
  localparam int unsigned TASK_RX      = 0;
  localparam int unsigned TASK_TX      = 1;
  localparam int unsigned TASK_STOP    = 2;
  localparam int unsigned TASK_SUSPEND = 3;
  localparam int unsigned TASK_RESUME  = 4;

  localparam int unsigned EV_STOPPED   = 0;
  localparam int unsigned EV_ERROR     = 1;
  localparam int unsigned EV_SUSPENDED = 2;
  localparam int unsigned EV_RX_BEGAN  = 3;
  localparam int unsigned EV_TX_BEGAN  = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    TSEV_RUN_IDLE,
    TSEV_RUN_SUSP_WAIT,
    TSEV_RUN_SUSPENDED
  } tsev_susp_t;

endpackage

//--- rtl/tsev_sub_slot.sv
// one subscription: channel select, enable, task trigger pulse
// assumes channel events are one-cycle pulses on the same clock
`timescale 1ns/1ps
module tsev_sub_slot
  import tsev_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    wr_en,
  input  wire logic [31:0]             wr_data,
  input  wire logic [NUM_CHANNELS-1:0] channel_event,
  output logic      [31:0]             sub_value,
  output logic                         task_fire
);

  logic [CHAN_IDX_W-1:0] channel_index_q;
  logic [CHAN_IDX_W-1:0] channel_index_d;
  logic               enable_q;
  logic               enable_d;
  logic               fire_q;
  logic               fire_d;

  always_comb begin
    channel_index_d = channel_index_q;
    enable_d        = enable_q;
    if (wr_en) begin
      channel_index_d = wr_data[SUB_CHANNEL_INDEX_LSB +: CHAN_IDX_W];
      enable_d        = wr_data[SUB_EN_BIT];
    end
    // disabled slots ignore every channel
    fire_d = enable_q & channel_event[channel_index_q];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_index_q <= SUB_RESET[SUB_CHANNEL_INDEX_LSB +: CHAN_IDX_W];
      enable_q        <= SUB_RESET[SUB_EN_BIT];
      fire_q          <= 1'b0;
    end else begin
      channel_index_q <= channel_index_d;
      enable_q        <= enable_d;
      fire_q          <= fire_d;
    end
  end

  always_comb begin
    sub_value                           = '0;
    sub_value[SUB_CHANNEL_INDEX_LSB +: CHAN_IDX_W] = channel_index_q;
    sub_value[SUB_EN_BIT]               = enable_q;
  end
  assign task_fire = fire_q;

  a_fire_follows_chan: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable_q && channel_event[channel_index_q] && !wr_en) |=> task_fire)
    else $error("subscribed event did not fire task");
  a_disabled_silent: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable_q |=> !task_fire)
    else $error("disabled subscription fired task");

endmodule

//--- rtl/tsev_event_flag.sv
// one sticky event flag, set by the engine, written by software
// assumes engine pulses are on the same clock
`timescale 1ns/1ps
module tsev_event_flag
  import tsev_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic set_pulse,
  input  wire logic wr_en,
  input  wire logic wr_bit,
  output logic      flag
);

  logic flag_q;
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (wr_en) begin
      flag_d = wr_bit;
    end
    // a set arriving with a software clear must not be lost
    if (set_pulse) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= EV_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

  a_set_wins_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    set_pulse |=> flag)
    else $error("event pulse lost");

endmodule

//--- rtl/tsev_bank.sv
// subscription and event flag bank of a two-wire master, AXI4-Lite slave
// assumes the transaction engine and interconnect share aclk
//
// What this block does
// - begin-receive subscription: channel index, enable, trigger
// - begin-transmit subscription; disabled ignores channel events
// - stop subscription selects channel triggering stop task
// - suspend subscription triggers suspend on selected channel
// - resume subscription triggers resume on selected channel
// - suspended flag after suspend accepted and bus halted
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module tsev_bank
  import tsev_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic [NUM_CHANNELS-1:0] channel_event,
  input  wire logic                    engine_bus_halted,
  input  wire logic                    engine_stopped,
  input  wire logic                    engine_error,
  input  wire logic                    engine_receive_began,
  input  wire logic                    engine_transmit_began,
  output logic                         begin_receive_task,
  output logic                         begin_transmit_task,
  output logic                         stop_task,
  output logic                         suspend_task,
  output logic                         resume_task
);

  ////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  logic              aw_held_q;
  logic              aw_held_d;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [ADDR_W-1:0] aw_addr_d;
  logic              w_held_q;
  logic              w_held_d;
  logic [31:0]       w_data_q;
  logic [31:0]       w_data_d;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;
  logic [1:0]        bresp_d;
  logic              wr_go;
  logic              wr_hit;
  logic [NUM_TASKS-1:0]  sub_wr;
  logic [NUM_EVENTS-1:0] ev_wr;

  localparam logic [11:0] SUB_OFS [NUM_TASKS] = '{OFS_SUB_RX, OFS_SUB_TX,
    OFS_SUB_STOP, OFS_SUB_SUSPEND, OFS_SUB_RESUME};
  localparam logic [11:0] EV_OFS [NUM_EVENTS] = '{OFS_EV_STOPPED,
    OFS_EV_ERROR, OFS_EV_SUSPENDED, OFS_EV_RX_BEGAN, OFS_EV_TX_BEGAN};

  // ready only while the slot is empty, so one write is in flight
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && !aw_held_q && !bvalid_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q && !bvalid_q) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
    end
    if (wr_go) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  assign wr_go = aw_held_q && w_held_q && !bvalid_q;

  // byte lane 0 holds the flag bit; lane 3 holds subscription enable
  always_comb begin
    wr_hit = 1'b0;
    for (int i = 0; i < NUM_TASKS; i++) begin
      sub_wr[i] = wr_go && (aw_addr_q[11:2] == SUB_OFS[i][11:2]);
      wr_hit    = wr_hit | sub_wr[i];
    end
    for (int i = 0; i < NUM_EVENTS; i++) begin
      ev_wr[i] = wr_go && (aw_addr_q[11:2] == EV_OFS[i][11:2]);
      wr_hit   = wr_hit | ev_wr[i];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q  <= 1'b0;
      w_data_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // strobes are held beside the data so partial writes keep other bytes
  logic [3:0] w_strb_q;
  logic [3:0] w_strb_d;
  always_comb begin
    w_strb_d = w_strb_q;
    if (s_axi_wvalid && !w_held_q && !bvalid_q) begin
      w_strb_d = s_axi_wstrb;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_strb_q <= '0;
    end else begin
      w_strb_q <= w_strb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // subscriptions and event flags

  logic [31:0]           sub_value [NUM_TASKS];
  logic [NUM_TASKS-1:0]  task_fire;
  logic [NUM_EVENTS-1:0] ev_set;
  logic [NUM_EVENTS-1:0] ev_flag;
  logic                  suspend_halted;

  genvar g;
  generate
    for (g = 0; g < NUM_TASKS; g++) begin : g_sub
      logic [31:0] merged;
      always_comb begin
        for (int b = 0; b < 4; b++) begin
          merged[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8]
                                         : sub_value[g][b*8 +: 8];
        end
      end
      tsev_sub_slot u_slot (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .wr_en         (sub_wr[g]),
        .wr_data       (merged),
        .channel_event (channel_event),
        .sub_value     (sub_value[g]),
        .task_fire     (task_fire[g])
      );
    end
    for (g = 0; g < NUM_EVENTS; g++) begin : g_ev
      tsev_event_flag u_flag (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .set_pulse (ev_set[g]),
        .wr_en     (ev_wr[g] && w_strb_q[0]),
        .wr_bit    (w_data_q[0]),
        .flag      (ev_flag[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // suspend tracking: flag only once the engine reports the bus halted

  tsev_susp_t susp_q;
  tsev_susp_t susp_d;

  always_comb begin
    susp_d         = susp_q;
    suspend_halted = 1'b0;
    case (susp_q)
      TSEV_RUN_IDLE: begin
        if (task_fire[TASK_SUSPEND]) begin
          susp_d = TSEV_RUN_SUSP_WAIT;
        end
      end
      TSEV_RUN_SUSP_WAIT: begin
        if (task_fire[TASK_RESUME]) begin
          susp_d = TSEV_RUN_IDLE;
        end else if (engine_bus_halted) begin
          susp_d         = TSEV_RUN_SUSPENDED;
          suspend_halted = 1'b1;
        end
      end
      TSEV_RUN_SUSPENDED: begin
        if (task_fire[TASK_RESUME]) begin
          susp_d = TSEV_RUN_IDLE;
        end
      end
      default: susp_d = TSEV_RUN_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      susp_q <= TSEV_RUN_IDLE;
    end else begin
      susp_q <= susp_d;
    end
  end

  always_comb begin
    ev_set               = '0;
    ev_set[EV_STOPPED]   = engine_stopped;
    ev_set[EV_ERROR]     = engine_error;
    ev_set[EV_SUSPENDED] = suspend_halted;
    ev_set[EV_RX_BEGAN]  = engine_receive_began;
    ev_set[EV_TX_BEGAN]  = engine_transmit_began;
  end

  ////////////////////////////////////////////////////////////////////////
  // task outputs; a stop while suspended is the far side's fault

  logic [NUM_TASKS-1:0] task_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      task_q <= '0;
    end else begin
      task_q <= task_fire;
    end
  end
  assign begin_receive_task  = task_q[TASK_RX];
  assign begin_transmit_task = task_q[TASK_TX];
  assign stop_task           = task_q[TASK_STOP];
  assign suspend_task        = task_q[TASK_SUSPEND];
  assign resume_task         = task_q[TASK_RESUME];

  ////////////////////////////////////////////////////////////////////////
  // read channel: answer one cycle after the address is taken

  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic        rd_hit;
  logic [31:0] rd_word;

  always_comb begin
    rd_hit  = 1'b0;
    rd_word = '0;
    for (int i = 0; i < NUM_TASKS; i++) begin
      if (s_axi_araddr[11:2] == SUB_OFS[i][11:2]) begin
        rd_hit  = 1'b1;
        rd_word = sub_value[i];
      end
    end
    for (int i = 0; i < NUM_EVENTS; i++) begin
      if (s_axi_araddr[11:2] == EV_OFS[i][11:2]) begin
        rd_hit  = 1'b1;
        rd_word = {31'h0000_0000, ev_flag[i]};
      end
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_word;
      rresp_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_rx_two_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    (sub_value[TASK_RX][SUB_EN_BIT] && !sub_wr[TASK_RX]
     && channel_event[sub_value[TASK_RX][CHAN_IDX_W-1:0]])
    |=> ##1 begin_receive_task)
    else $error("begin receive not triggered");
  a_tx_ignored_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !sub_value[TASK_TX][SUB_EN_BIT] |=> ##1 !begin_transmit_task)
    else $error("transmit triggered while disabled");
  a_stop_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_task |-> $past(task_fire[TASK_STOP]))
    else $error("stop task without subscribed event");
  a_suspend_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    suspend_task |-> $past(task_fire[TASK_SUSPEND]))
    else $error("suspend task without subscribed event");
  a_resume_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    resume_task |-> $past(task_fire[TASK_RESUME]))
    else $error("resume task without subscribed event");
  a_susp_flag_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    (susp_q == TSEV_RUN_SUSP_WAIT && engine_bus_halted
     && !task_fire[TASK_RESUME]) |=> ev_flag[EV_SUSPENDED])
    else $error("suspended flag not raised after halt");
  a_susp_no_early: assert property (@(posedge aclk) disable iff (!aresetn)
    (susp_q == TSEV_RUN_IDLE && !ev_flag[EV_SUSPENDED] && !ev_wr[EV_SUSPENDED])
    |=> !ev_flag[EV_SUSPENDED])
    else $error("suspended flag raised without halt");
  a_engine_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    (engine_stopped || engine_error) |=>
      (ev_flag[EV_STOPPED] || !$past(engine_stopped))
      && (ev_flag[EV_ERROR] || !$past(engine_error)))
    else $error("engine event flag missed");
  a_bresp_one_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response not raised");

  c_rx_fired:   cover property (@(posedge aclk) begin_receive_task);
  c_suspended:  cover property (@(posedge aclk) susp_q == TSEV_RUN_SUSPENDED);
  c_set_clear:  cover property (@(posedge aclk)
    ev_wr[EV_ERROR] && engine_error);
  c_bad_read:   cover property (@(posedge aclk)
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule

//--- bench/tsev_engine_model.sv
// behavioural transaction engine facing the subscription and flag bank
// assumes task pulses arrive one cycle wide on aclk
`timescale 1ns/1ps
module tsev_engine_model
  import tsev_pkg::*;
#(
  parameter logic [7:0] HALT_DELAY = 8'h14
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic begin_receive_task,
  input  wire logic begin_transmit_task,
  input  wire logic stop_task,
  input  wire logic suspend_task,
  input  wire logic resume_task,
  input  wire logic inject_error,
  output logic      engine_bus_halted,
  output logic      engine_stopped,
  output logic      engine_error,
  output logic      engine_receive_began,
  output logic      engine_transmit_began
);
  logic       susp_q;
  logic [7:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // a real bus halts only at a bit boundary, so the halt is slow on purpose
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      susp_q                <= 1'b0;
      cnt_q                 <= 8'h00;
      engine_bus_halted     <= 1'b0;
      engine_stopped        <= 1'b0;
      engine_error          <= 1'b0;
      engine_receive_began  <= 1'b0;
      engine_transmit_began <= 1'b0;
    end else begin
      engine_receive_began  <= begin_receive_task;
      engine_transmit_began <= begin_transmit_task;
      engine_stopped        <= stop_task;
      engine_error          <= inject_error;
      if (suspend_task) begin
        susp_q <= 1'b1;
        cnt_q  <= 8'h00;
      end else if (resume_task) begin
        susp_q            <= 1'b0;
        engine_bus_halted <= 1'b0;
      end else if (susp_q && cnt_q < HALT_DELAY) begin
        cnt_q <= cnt_q + 8'h01;
      end else if (susp_q) begin
        engine_bus_halted <= 1'b1;
      end
    end
  end
endmodule

//--- bench/twi_master_subscribe_events_tb_top.sv
// testbench for the subscription and event flag bank
// assumes the engine model file is compiled before this one
`timescale 1ns/1ps
module twi_master_subscribe_events_tb_top
  import tsev_pkg::*;
;
  localparam logic [11:0] OFS [10] = '{OFS_SUB_RX, OFS_SUB_TX, OFS_SUB_STOP,
    OFS_SUB_SUSPEND, OFS_SUB_RESUME, OFS_EV_STOPPED, OFS_EV_ERROR,
    OFS_EV_SUSPENDED, OFS_EV_RX_BEGAN, OFS_EV_TX_BEGAN};
  localparam logic [3:0] CH [5] = '{4'h3, 4'h6, 4'h9, 4'hc, 4'hf};
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, inject_error, engine_bus_halted;
  logic engine_stopped, engine_error, engine_receive_began;
  logic engine_transmit_began, begin_receive_task, begin_transmit_task;
  logic stop_task, suspend_task, resume_task;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] channel_event;
  logic [7:0]  fired [5];
  logic [31:0] exp_cnt [5];
  logic [31:0] rd;
  logic [4:0]  tasks;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;

  assign tasks = {resume_task, suspend_task, stop_task,
                  begin_transmit_task, begin_receive_task};

  tsev_bank i_tsev_bank (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .channel_event, .engine_bus_halted, .engine_stopped, .engine_error,
    .engine_receive_began, .engine_transmit_began, .begin_receive_task,
    .begin_transmit_task, .stop_task, .suspend_task, .resume_task);
  tsev_engine_model i_tsev_engine_model (.aclk, .aresetn,
    .begin_receive_task, .begin_transmit_task, .stop_task, .suspend_task,
    .resume_task, .inject_error, .engine_bus_halted, .engine_stopped,
    .engine_error, .engine_receive_began, .engine_transmit_began);

  ////////////////////////////////////////////////////////////////////////////
  always #12.5 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // counted here, not in the model, so a stray pulse is seen at once
  always @(posedge aclk) begin
    for (int i = 0; i < 5; i++)
      fired[i] <= !aresetn ? 8'h00 : fired[i] + {7'h00, tasks[i]};
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
                         input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp,
                          input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s resp %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [11:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rsp = s_axi_rresp;
        rd  = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask

  task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
    axi_write(a, d);
    chk_resp(rsp, RESP_OKAY, "write");
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    axi_read(a);
    chk_resp(rsp, RESP_OKAY, "read");
    chk_val(rd, exp, "read data");
  endtask

  task automatic pulse(input logic [3:0] c);
    channel_event <= 16'h0001 << c;
    @(posedge aclk);
    channel_event <= 16'h0000;
    repeat (4) @(posedge aclk);
  endtask

  task automatic chk_counts();
    for (int j = 0; j < 5; j++)
      chk_val({24'h000000, fired[j]}, exp_cnt[j], "task count");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, inject_error} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 28'h0000000;
    s_axi_wdata = 32'h0000_0000;
    channel_event = 16'h0000;
    exp_cnt = '{default: 32'h0000_0000};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int k = 0; k < 10; k++) rd_chk(OFS[k], 32'h0000_0000);
    for (int k = 0; k < 5; k++) begin
      wr_ok(OFS[k], {28'h8000000, CH[k]});
      rd_chk(OFS[k], {28'h8000000, CH[k]});
    end
    // stop is triggered before suspend, never while suspended
    for (int k = 0; k < 5; k++) begin
      pulse(CH[k] - 4'h1);
      pulse(CH[k]);
      exp_cnt[k]++;
      chk_counts();
      if (k == TASK_SUSPEND) begin
        rd_chk(OFS[5 + EV_SUSPENDED], 32'h0000_0000);
        repeat (30) @(posedge aclk);
        rd_chk(OFS[5 + EV_SUSPENDED], 32'h0000_0001);
      end
    end
    inject_error <= 1'b1;
    @(posedge aclk);
    inject_error <= 1'b0;
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 5; i++) begin
      rd_chk(OFS[5 + i], 32'h0000_0001);
      wr_ok(OFS[5 + i], 32'h0000_0000);
      rd_chk(OFS[5 + i], 32'h0000_0000);
    end
    wr_ok(OFS[5 + EV_STOPPED], 32'h0000_0001);
    rd_chk(OFS[5 + EV_STOPPED], 32'h0000_0001);
    wr_ok(OFS_SUB_TX, 32'h0000_0006);
    pulse(4'h6);
    chk_counts();
    wr_ok(OFS_SUB_RX, 32'h8000_000f);
    pulse(4'h3);
    pulse(4'hf);
    exp_cnt[TASK_RX]++;
    exp_cnt[TASK_RESUME]++;
    chk_counts();
    axi_write(12'h084, 32'h8000_0001);
    chk_resp(rsp, RESP_SLVERR, "unmapped write");
    axi_read(12'h084);
    chk_resp(rsp, RESP_SLVERR, "unmapped read");
    chk_val(rd, 32'h0000_0000, "unmapped data");
    rd_chk(OFS_SUB_STOP, {28'h8000000, CH[TASK_STOP]});
    print_verdict();
  end
endmodule
